// ### sim/eis_monitor.sv
// Checker of bus timing and pending flag behaviour at the ports of the sense block.
`timescale 1ns/1ns
`default_nettype none
module eis_monitor
    import eis_pkg::*;
#(
    parameter int PINS = EIS_PINS
)
(
    input wire logic                   clk,
    input wire logic                   reset,
    input wire eis_pkg::eis_av_req_t   avs_req,
    input wire logic                   avs_waitrequest,
    input wire logic [31:0]            avs_readdata,
    input wire logic [PINS-1:0]        ext_request_pin_n,
    input wire eis_pkg::eis_handling_t handling,
    input wire logic [PINS-1:0]        irq_forward,
    input wire logic                   irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic [3:0][PINS-1:0] hist_reg;
    logic [PINS-1:0]      quiet;
    logic                 rq;
    // A pin is quiet once every synchroniser stage has seen it high, so no set can beat a clear.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hist_reg <= '1;
        end else begin
            hist_reg <= {hist_reg[2:0], ext_request_pin_n};
        end
    end
    assign quiet = ext_request_pin_n & hist_reg[0] & hist_reg[1] & hist_reg[2] & hist_reg[3];
    assign rq = avs_req.read || avs_req.write;
    a_wait_one_cycle: assert property (avs_waitrequest && rq |=> !avs_waitrequest)
        else $error("no answer one cycle after a request");
    a_wait_low_once: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for two cycles");
    a_wait_idle_high: assert property (avs_waitrequest && !rq |=> avs_waitrequest)
        else $error("waitrequest low without a request");
    a_status_rsvd_zero: assert property (
        !avs_waitrequest && avs_req.read && avs_req.address == OFS_STATUS |-> avs_readdata[31:12] == '0)
        else $error("reserved status bits not zero");
    a_exc_clears_flag: assert property (
        |(handling.exc_start & quiet) |=> (irq_forward & $past(handling.exc_start & quiet)) == '0)
        else $error("handling start left a flag set");
    a_xfer_clears_flag: assert property (
        |(handling.xfer_activate & ~handling.xfer_end_int_select & quiet)
        |=> (irq_forward & $past(handling.xfer_activate & ~handling.xfer_end_int_select & quiet)) == '0)
        else $error("transfer activation left a flag set");
    a_flag_stays_set: assert property (
        |($past(irq_forward) & ~irq_forward & ~$past(handling.exc_start | handling.xfer_activate))
        |-> $past(avs_req.write && !avs_waitrequest))
        else $error("flag dropped without a cause");
    a_rdata_held: assert property ($changed(avs_readdata) |-> $past(avs_req.read && avs_waitrequest))
        else $error("read data changed without a read");
endmodule
bind eis_top eis_monitor #(.PINS(PINS)) u_mon (.clk(clk), .reset(reset), .avs_req(avs_req),
    .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata), .ext_request_pin_n(ext_request_pin_n),
    .handling(handling), .irq_forward(irq_forward), .irq(irq));
`default_nettype wire

// ### sim/eis_pin_model.sv
// Board-side model of the request pins with a prompt or slow response.
`timescale 1ns/1ns
`default_nettype none
module eis_pin_model
    import eis_pkg::*;
(
    input  wire logic                clk,
    input  wire logic [EIS_PINS-1:0] level_cmd,
    input  wire logic                slow,
    output logic      [EIS_PINS-1:0] ext_request_pin_n
);
    logic [2:0][EIS_PINS-1:0] dly_reg = '1;
    // Pins idle high; a low request is held until the bench lets it go.
    always @(posedge clk) begin
        dly_reg <= {dly_reg[1:0], level_cmd};
    end
    assign ext_request_pin_n = slow ? dly_reg[2] : dly_reg[0];
endmodule
`default_nettype wire

// ### sim/tb_eis_top.sv
// Self-checking bench of the sense block against expected flag values written out for each step.
`timescale 1ns/1ns
`default_nettype none
module tb_eis_top;
    import eis_pkg::*;
    logic                clk = 1'b0;
    logic                reset = 1'b1;
    eis_av_req_t         req = '0;
    eis_handling_t       hnd = '0;
    logic [EIS_PINS-1:0] cmd = '1;
    logic                slow = 1'b0;
    logic                wreq;
    logic [31:0]         rdata;
    logic [EIS_PINS-1:0] pins_n;
    logic [EIS_PINS-1:0] fwd;
    logic                irq;
    int                  err_count = 0;
    int                  checked = 0;
    int                  p;
    int                  m;
    logic [31:0]         q;
    logic [31:0]         b;
    logic [31:0]         en;
    logic [31:0]         exp_f;

    always #50 clk = ~clk;
    eis_top dut (.clk(clk), .reset(reset), .avs_req(req), .avs_waitrequest(wreq), .avs_readdata(rdata),
        .ext_request_pin_n(pins_n), .handling(hnd), .irq_forward(fwd), .irq(irq));
    eis_pin_model u_pins (.clk(clk), .level_cmd(cmd), .slow(slow), .ext_request_pin_n(pins_n));

    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // The request is held until waitrequest is sampled low; data are taken at that same edge.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: 4'hf};
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        q = rdata;
        req <= '0;
        if (n >= 20) begin
            chk(n, 0);
            final_report();
        end
    endtask
    task automatic st(input logic [31:0] e);
        bus(0, OFS_STATUS, 0);
        chk(q, e);
    endtask
    task automatic clr;
        bus(0, OFS_STATUS, 0);
        bus(1, OFS_STATUS, 0);
    endtask
    task automatic pulse(input eis_handling_t h);
        @(posedge clk);
        hnd <= h;
        @(posedge clk);
        hnd <= '0;
        repeat (2) @(posedge clk);
    endtask
    task automatic pin(input logic lv);
        @(posedge clk);
        cmd <= lv ? '1 : ~b[11:0];
        repeat (10) @(posedge clk);
    endtask

    initial begin
        void'($urandom(32'h0025));
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        bus(0, OFS_SENSE_LOW, 0);
        chk(q, 0);
        st(0);
        bus(0, 8'h20, 0);
        chk(q, 0);
        en = $urandom;
        bus(1, OFS_SENSE_LOW, en);
        bus(0, OFS_SENSE_LOW, 0);
        chk(q, {16'h0, en[15:0]});
        p = $urandom_range(7, 0);
        b = 32'h1 << p;
        for (m = 0; m < 4; m++) begin
            slow <= m[0];
            bus(1, OFS_REQ_ENABLE, 0);
            bus(1, OFS_SENSE_LOW, m << (2 * p));
            clr();
            bus(1, OFS_REQ_ENABLE, b);
            pin(0);
            exp_f = (m != 2) ? b : 0;
            st(exp_f);
            chk({20'h0, fwd}, exp_f);
            pulse('{exc_start: b[11:0], default: '0});
            if (m != 0) exp_f = 0;
            st(exp_f);
            pin(1);
            if (m >= 2) exp_f = b;
            st(exp_f);
            if (m[0]) clr();
            else pulse('{exc_start: b[11:0], default: '0});
            st(0);
        end
        bus(1, OFS_EVT_CLEAR, 32'hfff);
        bus(1, OFS_EVT_ENABLE, b);
        bus(1, OFS_REQ_ENABLE, 32'hfff);
        pin(0);
        chk({31'h0, irq}, 1);
        pulse('{xfer_activate: b[11:0], xfer_end_int_select: b[11:0], default: '0});
        st(b);
        pulse('{xfer_activate: b[11:0], default: '0});
        st(0);
        // Any status write disarms, so the zero write below has no earlier read of one behind it.
        bus(1, OFS_STATUS, 32'h0fff);
        pin(1);
        bus(1, OFS_STATUS, 0);
        st(b);
        bus(1, OFS_STATUS, 32'h0fff);
        bus(1, OFS_STATUS, 0);
        st(b);
        bus(0, OFS_EVT_STATUS, 0);
        chk(q, b);
        bus(1, OFS_EVT_ENABLE, 0);
        @(posedge clk);
        chk({31'h0, irq}, 0);
        bus(1, OFS_EVT_CLEAR, b);
        bus(0, OFS_EVT_STATUS, 0);
        chk(q, 0);
        en = $urandom & 32'hfff;
        bus(1, OFS_REQ_ENABLE, en);
        @(posedge clk);
        chk({20'h0, fwd}, en & b);
        bus(1, OFS_REQ_ENABLE, 32'hfff);
        pulse('{xfer_activate: b[11:0], default: '0});
        st(0);
        pin(0);
        pin(1);
        st(b);
        // A reset in mid-run must bring back the low sense register and the status, with the pin released first.
        bus(1, OFS_SENSE_LOW, en);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        bus(0, OFS_SENSE_LOW, 0);
        chk(q, 0);
        st(0);
        chk({20'h0, fwd}, 0);
        final_report();
    end
endmodule
`default_nettype wire

// ### src/eis_pending_flag.sv
// One sticky pending flag with the read-one-then-write-zero software clear.
`timescale 1ns/1ns
`default_nettype none
module eis_pending_flag
    import eis_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic set_req,
    input  wire logic hw_clear,
    input  wire logic sw_read_one,
    input  wire logic sw_write,
    input  wire logic sw_wbit,
    output logic      pending_flag
);
    logic armed_reg;
    logic sw_clear;

    // A write of one never changes the flag; a zero clears only once armed.
    assign sw_clear = sw_write & ~sw_wbit & armed_reg;

    // Any write disarms, so each clear needs a fresh read of one.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            armed_reg <= 1'b0;
        end else if (sw_write) begin
            armed_reg <= 1'b0;
        end else if (sw_read_one) begin
            armed_reg <= 1'b1;
        end
    end

    // A new request in the clearing cycle wins over the clear.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pending_flag <= 1'b0;
        end else if (set_req) begin
            pending_flag <= 1'b1;
        end else if (sw_clear | hw_clear) begin
            pending_flag <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### src/eis_pin_sense.sv
// One request pin: synchroniser, edge detection and sense selection.
`timescale 1ns/1ns
`default_nettype none
module eis_pin_sense
    import eis_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       ext_request_pin_n,
    input  wire logic [1:0] sense,
    output logic            pin_level,
    output logic            set_req
);
    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;
    logic fall_seen;
    logic rise_seen;

    // The first stage is read only by the second stage.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync1_reg <= PIN_IDLE_LEVEL;
            sync2_reg <= PIN_IDLE_LEVEL;
            prev_reg  <= PIN_IDLE_LEVEL;
        end else begin
            sync1_reg <= ext_request_pin_n;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    // Each transition shows for one cycle only, so it sets the flag once.
    assign fall_seen = prev_reg & ~sync2_reg;
    assign rise_seen = ~prev_reg & sync2_reg;
    assign pin_level = sync2_reg;

    always_comb begin
        case (eis_sense_t'(sense))
            SENSE_LOW_LEVEL: set_req = ~sync2_reg;
            SENSE_FALL:      set_req = fall_seen;
            SENSE_RISE:      set_req = rise_seen;
            SENSE_BOTH:      set_req = fall_seen | rise_seen;
            default:         set_req = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// ### src/eis_pkg.sv
// Package with register map, reset values and shared types of the external request sense block.
package eis_pkg;

    localparam int          EIS_PINS         = 12;
    localparam int          EIS_LOW_PINS     = 8;
    localparam int          EIS_HIGH_PINS    = 4;
    localparam int          EIS_ADDR_W       = 8;
    localparam int          EIS_DATA_W       = 32;
    localparam int          EIS_REG_W        = 16;

    localparam logic [7:0]  OFS_SENSE_LOW    = 8'h00;
    localparam logic [7:0]  OFS_SENSE_HIGH   = 8'h04;
    localparam logic [7:0]  OFS_STATUS       = 8'h08;
    localparam logic [7:0]  OFS_REQ_ENABLE   = 8'h0c;
    localparam logic [7:0]  OFS_EVT_STATUS   = 8'h10;
    localparam logic [7:0]  OFS_EVT_CLEAR    = 8'h14;
    localparam logic [7:0]  OFS_EVT_ENABLE   = 8'h18;

    localparam logic [15:0] RST_SENSE_LOW    = 16'h0000;
    localparam logic [7:0]  RST_SENSE_HIGH   = 8'h00;
    localparam logic [11:0] RST_STATUS       = 12'h000;
    localparam logic [11:0] RST_REQ_ENABLE   = 12'h000;
    localparam logic [11:0] RST_EVT          = 12'h000;
    localparam logic [31:0] RST_READDATA     = 32'h0000_0000;

    localparam int          RISE_BIT         = 1;
    localparam int          FALL_BIT         = 0;
    localparam int          STATUS_RSVD_W    = 4;
    localparam int          HIGH_RSVD_W      = 8;
    localparam int          UPPER_ZERO_W     = 16;
    localparam logic        PIN_IDLE_LEVEL   = 1'b1;
    localparam int          SYNC_STAGES      = 2;

    typedef enum logic [1:0] {
        SENSE_LOW_LEVEL = 2'b00,
        SENSE_FALL      = 2'b01,
        SENSE_RISE      = 2'b10,
        SENSE_BOTH      = 2'b11
    } eis_sense_t;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } eis_bus_state_t;

    typedef struct packed {
        logic                  read;
        logic                  write;
        logic [EIS_ADDR_W-1:0] address;
        logic [EIS_DATA_W-1:0] writedata;
        logic [3:0]            byteenable;
    } eis_av_req_t;

    typedef struct packed {
        logic [EIS_PINS-1:0] exc_start;
        logic [EIS_PINS-1:0] xfer_activate;
        logic [EIS_PINS-1:0] xfer_end_int_select;
    } eis_handling_t;

endpackage

// ### src/eis_top.sv
// Sense selection, pending flags and register slave for twelve active-low request pins.
//
// Operation
// - Sense 00: request while pin is low.
// - Sense 01: request on each falling edge.
// - Sense 10: request on each rising edge.
// - Sense 11: request on both edges.
// - Low sense: pin n rise 2n+1, fall 2n.
// - Sense bits reset to zero, read/write.
// - Status holds pins 11..0 flags, reset zero.
// - Selected condition sets the pin's flag.
// - Zero write after reading one clears.
// - Writing one to a flag does nothing.
// - Level mode: handling start clears if pin high.
// - Edge modes: handling start clears the flag.
// - Transfer activation with select zero clears.
// - Status bits 15..12 read as zero.
// - Only enabled flags are forwarded for handling.
`timescale 1ns/1ns
`default_nettype none
module eis_top
    import eis_pkg::*;
#(
    parameter int PINS = EIS_PINS
)
(
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire eis_pkg::eis_av_req_t   avs_req,
    output logic                        avs_waitrequest,
    output logic [31:0]                 avs_readdata,
    input  wire logic [PINS-1:0]        ext_request_pin_n,
    input  wire eis_pkg::eis_handling_t handling,
    output logic [PINS-1:0]             irq_forward,
    output logic                        irq
);
    eis_bus_state_t    state_reg;
    eis_bus_state_t    state_next;
    logic [15:0]       sense_control_low_reg;
    logic [7:0]        sense_control_high_reg;
    logic [11:0]       request_enable_reg;
    logic [11:0]       evt_status_reg;
    logic [11:0]       evt_enable_reg;
    logic [31:0]       readdata_next;
    logic [11:0]       request_status;
    logic [23:0]       sense_all;
    logic [PINS-1:0]   pin_level;
    logic [PINS-1:0]   set_req;
    logic [PINS-1:0]   hw_clear;
    logic [PINS-1:0]   sw_read_one;
    logic [PINS-1:0]   flag_rose;
    logic [11:0]       flag_prev_reg;
    logic              acc_write;
    logic              acc_read;
    logic              lane0;
    logic              lane1;
    logic              hit_sense_low;
    logic              hit_sense_high;
    logic              hit_status;
    logic              hit_req_enable;
    logic              hit_evt_status;
    logic              hit_evt_clear;
    logic              hit_evt_enable;
    logic [15:0]       wdata16;

    // Address decode; unmapped offsets read as zero and ignore writes.
    assign hit_sense_low  = (avs_req.address == OFS_SENSE_LOW);
    assign hit_sense_high = (avs_req.address == OFS_SENSE_HIGH);
    assign hit_status     = (avs_req.address == OFS_STATUS);
    assign hit_req_enable = (avs_req.address == OFS_REQ_ENABLE);
    assign hit_evt_status = (avs_req.address == OFS_EVT_STATUS);
    assign hit_evt_clear  = (avs_req.address == OFS_EVT_CLEAR);
    assign hit_evt_enable = (avs_req.address == OFS_EVT_ENABLE);

    assign lane0   = avs_req.byteenable[0];
    assign lane1   = avs_req.byteenable[1];
    assign wdata16 = avs_req.writedata[15:0];

    // One wait cycle per access: the request is seen in idle, answered in ack.
    always_comb begin
        case (state_reg)
            BUS_IDLE: begin
                if (avs_req.read | avs_req.write) begin
                    state_next = BUS_ACK;
                end else begin
                    state_next = BUS_IDLE;
                end
            end
            BUS_ACK:  state_next = BUS_IDLE;
            default:  state_next = BUS_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= BUS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign avs_waitrequest = (state_reg != BUS_ACK);
    assign acc_write       = (state_reg == BUS_ACK) & avs_req.write;
    assign acc_read        = (state_reg == BUS_ACK) & avs_req.read;

    // Read data are captured in idle so they stand when waitrequest drops.
    always_comb begin
        readdata_next = RST_READDATA;
        if (hit_sense_low) begin
            readdata_next[15:0] = sense_control_low_reg;
        end else if (hit_sense_high) begin
            readdata_next[7:0] = sense_control_high_reg;
        end else if (hit_status) begin
            readdata_next[15:0] = {{STATUS_RSVD_W{1'b0}}, request_status};
        end else if (hit_req_enable) begin
            readdata_next[11:0] = request_enable_reg;
        end else if (hit_evt_status) begin
            readdata_next[11:0] = evt_status_reg;
        end else if (hit_evt_enable) begin
            readdata_next[11:0] = evt_enable_reg;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            avs_readdata <= RST_READDATA;
        end else if (state_reg == BUS_IDLE && avs_req.read) begin
            avs_readdata <= readdata_next;
        end
    end

    // Sense fields: pin n uses bit 2n+1 for rise and bit 2n for fall.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sense_control_low_reg <= RST_SENSE_LOW;
        end else if (acc_write && hit_sense_low) begin
            if (lane0) begin
                sense_control_low_reg[7:0] <= wdata16[7:0];
            end
            if (lane1) begin
                sense_control_low_reg[15:8] <= wdata16[15:8];
            end
        end
    end

    // Bits 15..8 of the high sense register are not stored and read as zero.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sense_control_high_reg <= RST_SENSE_HIGH;
        end else if (acc_write && hit_sense_high && lane0) begin
            sense_control_high_reg <= wdata16[7:0];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            request_enable_reg <= RST_REQ_ENABLE;
        end else if (acc_write && hit_req_enable) begin
            if (lane0) begin
                request_enable_reg[7:0] <= wdata16[7:0];
            end
            if (lane1) begin
                request_enable_reg[11:8] <= wdata16[11:8];
            end
        end
    end

    assign sense_all = {sense_control_high_reg, sense_control_low_reg};

    // Arming uses the exact value returned, so only bits seen as one arm.
    assign sw_read_one = (acc_read && hit_status) ? avs_readdata[11:0] : 12'h000;

    genvar n;
    generate
        for (n = 0; n < PINS; n++) begin : g_pin
            logic       level_mode;
            logic       sw_write_n;
            logic       sw_wbit_n;

            eis_pin_sense u_sense (
                .clk               (clk),
                .reset             (reset),
                .ext_request_pin_n (ext_request_pin_n[n]),
                .sense             (sense_all[2*n+RISE_BIT -: 2]),
                .pin_level         (pin_level[n]),
                .set_req           (set_req[n])
            );

            assign level_mode = (sense_all[2*n+RISE_BIT -: 2] == SENSE_LOW_LEVEL);

            // Handling start clears a level request only once the pin is released.
            assign hw_clear[n] =
                (handling.exc_start[n] & level_mode & pin_level[n])
                | (handling.exc_start[n] & ~level_mode)
                | (handling.xfer_activate[n] & ~handling.xfer_end_int_select[n]);

            // A write without lane coverage of this bit leaves it alone.
            assign sw_write_n = acc_write & hit_status & (n < 8 ? lane0 : lane1);
            assign sw_wbit_n  = wdata16[n];

            eis_pending_flag u_flag (
                .clk          (clk),
                .reset        (reset),
                .set_req      (set_req[n]),
                .hw_clear     (hw_clear[n]),
                .sw_read_one  (sw_read_one[n]),
                .sw_write     (sw_write_n),
                .sw_wbit      (sw_wbit_n),
                .pending_flag (request_status[n])
            );
        end
    endgenerate

    // A pending flag alone is not forwarded; its request enable bit must be set too.
    assign irq_forward = request_status & request_enable_reg;

    // Block events are flags going from clear to pending.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flag_prev_reg <= RST_STATUS;
        end else begin
            flag_prev_reg <= request_status;
        end
    end

    assign flag_rose = request_status & ~flag_prev_reg;

    // Sticky event bits; a new event outweighs a simultaneous clear.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            evt_status_reg <= RST_EVT;
        end else if (acc_write && hit_evt_clear) begin
            evt_status_reg <= (evt_status_reg & ~wdata16[11:0]) | flag_rose;
        end else begin
            evt_status_reg <= evt_status_reg | flag_rose;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            evt_enable_reg <= RST_EVT;
        end else if (acc_write && hit_evt_enable) begin
            evt_enable_reg <= wdata16[11:0];
        end
    end

    assign irq = |(evt_status_reg & evt_enable_reg);
endmodule
`default_nettype wire
